// file: verilog/hps_pkg.sv
package hps_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int TICK_SLOW_US = 5000;
    localparam int TICK_FAST_US = 1000;
    localparam int WAIT_UNIT_US = 10000;
    localparam int TICK_SLOW_CYC = TICK_SLOW_US * CLK_MHZ;
    localparam int TICK_FAST_CYC = TICK_FAST_US * CLK_MHZ;
    localparam int WAIT_UNIT_CYC = WAIT_UNIT_US * CLK_MHZ;
    // ------------------------------------------------------------
    // register indexes, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_MODE = 6'h07;
    localparam logic [5:0] IDX_STATUS = 6'h08;
    localparam logic [5:0] IDX_GO = 6'h0c;
    localparam logic [5:0] IDX_LIBCFG = 6'h0d;
    localparam logic [5:0] IDX_RTAMP = 6'h0e;
    localparam logic [5:0] IDX_SLOT1 = 6'h0f;
    localparam logic [5:0] IDX_SLOT8 = 6'h16;
    localparam int NUM_SLOTS = 8;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int GO_BIT = 0;
    localparam int STATUS_BUSY_BIT = 7;
    localparam logic [7:0] RST_LIBCFG = 8'h00;
    localparam logic [7:0] RST_RTAMP = 8'h7f;
    localparam logic [7:0] RST_SLOT1 = 8'h01;
    localparam logic [7:0] RST_SLOTN = 8'h00;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [1:0] MODE_SEQUENCE = 2'h0;
    localparam logic [1:0] MODE_REALTIME = 2'h1;

    typedef struct packed {
        logic lib_sel;
        logic rsv6;
        logic interval_fast;
        logic [2:0] rsv4_2;
        logic [1:0] library_attenuation;
    } hps_libcfg_t;

    typedef struct packed {
        logic slot_delay_flag;
        logic [6:0] slot_identifier;
    } hps_slot_t;

    // library sample scaled to 100, 75, 50 or 25 percent
    function automatic logic signed [7:0] scale(input logic signed [7:0] s,
                                                input logic [1:0] g);
        logic signed [7:0] half;
        logic signed [7:0] quarter;
        half = s >>> 1;
        quarter = s >>> 2;
        unique case (g)
            2'h0: scale = s;
            2'h1: scale = 8'(half + quarter);
            2'h2: scale = half;
            2'h3: scale = quarter;
        endcase
    endfunction : scale
endpackage : hps_pkg

// file: verilog/hps_regs.sv
`timescale 1ns/1ps
// How it works
// - library select bit 7: 0 closed-loop resonant, 1 open-loop rotating mass
// - interval bit: playback tick every 5 ms when clear, 1 ms when set
// - attenuation code 0..3 scales library effects to 100/75/50/25 percent
// - attenuation ignored in real-time playback
// - real-time mode plus trigger drives the amplitude register onto load
// - amplitude register is an 8-bit two's-complement value
// - amplitude resets to 127; host may rewrite it live, output follows
// - delay flag set: idle 10 ms times slot value, no waveform
// - delay flag clear: slot value is a waveform identifier
// - identifier bits 6:0 index the waveform in the selected library
// - trigger starts the sequence at the first slot
// - after a slot, advance to the next and play it if non-zero
// - stop at first zero identifier or after all eight slots
// - trigger bit stays set while running, self-clears on completion
// - host clearing the trigger bit cancels playback at once
// - external hardware trigger sets the trigger bit like a write
module hps_regs #(
    parameter int unsigned TICK_SLOW_CYC = hps_pkg::TICK_SLOW_CYC,
    parameter int unsigned TICK_FAST_CYC = hps_pkg::TICK_FAST_CYC,
    parameter int unsigned WAIT_UNIT_CYC = hps_pkg::WAIT_UNIT_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_CE,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_HW_TRIG,
    input wire logic I_WAVE_DONE,
    input wire logic signed [7:0] I_LIB_SAMPLE,
    output logic signed [7:0] O_DRIVE_AMP,
    output logic O_DRIVE_EN,
    output logic [6:0] O_WAVE_ID,
    output logic O_WAVE_LIB,
    output logic O_WAVE_START,
    output logic O_PLAY_TICK
);
    typedef enum logic [2:0] {S_IDLE, S_FETCH, S_PLAY, S_WAIT, S_RTP} hps_state_t;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    hps_state_t state_reg, state_next;
    hps_pkg::hps_libcfg_t libcfg_reg;
    logic signed [7:0] rtamp_reg;
    logic [7:0] slot_reg [hps_pkg::NUM_SLOTS];
    logic [1:0] mode_reg;
    logic go_reg, go_next;
    logic [2:0] idx_reg, idx_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [6:0] left_reg, left_next;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic signed [7:0] amp_reg;
    logic drive_en_reg, start_reg, tick_reg, lib_reg;
    logic [6:0] id_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // one wait state keeps pready and prdata straight from flops
    wire access = I_PSEL & I_PENABLE & ~pready_reg;
    wire commit = I_PSEL & I_PENABLE & pready_reg;
    wire [5:0] pidx = I_PADDR[7:2];
    wire is_slot = (pidx >= hps_pkg::IDX_SLOT1) && (pidx <= hps_pkg::IDX_SLOT8);
    wire [5:0] slot_off = pidx - hps_pkg::IDX_SLOT1;
    wire [2:0] slot_sel = slot_off[2:0];
    wire known = is_slot || pidx == hps_pkg::IDX_MODE || pidx == hps_pkg::IDX_STATUS
        || pidx == hps_pkg::IDX_GO || pidx == hps_pkg::IDX_LIBCFG
        || pidx == hps_pkg::IDX_RTAMP;
    wire bad = ~known || (I_PADDR[1:0] != 2'h0);
    wire wr = commit & I_PWRITE & ~bad;
    wire wr_go = wr && pidx == hps_pkg::IDX_GO;
    wire [7:0] wdata = I_PWDATA[7:0];
    wire [7:0] status = {1'b1 & (state_reg != S_IDLE), 4'h0, idx_reg};
    wire [7:0] rd_byte =
        is_slot ? slot_reg[slot_sel] :
        pidx == hps_pkg::IDX_MODE ? {6'h00, mode_reg} :
        pidx == hps_pkg::IDX_STATUS ? status :
        pidx == hps_pkg::IDX_GO ? {7'h00, go_reg} :
        pidx == hps_pkg::IDX_LIBCFG ? libcfg_reg :
        pidx == hps_pkg::IDX_RTAMP ? rtamp_reg : 8'h00;

    // ------------------------------------------------------------
    // sequencer decode
    // ------------------------------------------------------------
    hps_pkg::hps_slot_t cur;
    assign cur = slot_reg[idx_reg];
    wire last = idx_reg == 3'(hps_pkg::NUM_SLOTS - 1);
    wire [31:0] cnt_lim = (state_reg == S_WAIT) ? WAIT_UNIT_CYC :
        libcfg_reg.interval_fast ? TICK_FAST_CYC : TICK_SLOW_CYC;
    wire cnt_wrap = cnt_reg == cnt_lim - 32'h1;
    wire slot_end = (state_reg == S_PLAY && I_WAVE_DONE)
        || (state_reg == S_WAIT && left_reg == 7'h00)
        || (state_reg == S_FETCH && cur.slot_delay_flag && cur.slot_identifier == 7'h00);
    wire zero_stop = state_reg == S_FETCH && !cur.slot_delay_flag
        && cur.slot_identifier == 7'h00;
    wire finish = go_reg && (zero_stop || (slot_end && last));
    wire start_next = go_reg && state_reg == S_FETCH && !cur.slot_delay_flag
        && cur.slot_identifier != 7'h00;
    wire go_set = I_HW_TRIG | (wr_go & wdata[hps_pkg::GO_BIT]);
    wire go_clr = (wr_go & ~wdata[hps_pkg::GO_BIT]) | finish;
    wire signed [7:0] scaled = hps_pkg::scale(I_LIB_SAMPLE,
        libcfg_reg.library_attenuation);

    // set wins over self-clear so a trigger at completion restarts
    assign go_next = go_set ? 1'b1 : go_clr ? 1'b0 : go_reg;

    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        left_next = left_reg;
        cnt_next = cnt_wrap ? 32'h0 : cnt_reg + 32'h1;
        if (!go_reg) begin
            state_next = S_IDLE;
        end else begin
            unique case (state_reg)
                S_IDLE: begin
                    idx_next = 3'h0;
                    state_next = (mode_reg == hps_pkg::MODE_REALTIME) ? S_RTP : S_FETCH;
                end
                S_FETCH: begin
                    cnt_next = 32'h0;
                    left_next = cur.slot_identifier;
                    if (cur.slot_delay_flag) begin
                        state_next = S_WAIT;
                    end else if (start_next) begin
                        state_next = S_PLAY;
                    end
                end
                S_WAIT: begin
                    if (cnt_wrap && left_reg != 7'h00) begin
                        left_next = left_reg - 7'h1;
                    end
                end
                S_PLAY, S_RTP: begin
                end
            endcase
            if (slot_end && !last) begin
                idx_next = idx_reg + 3'h1;
                state_next = S_FETCH;
            end
            if (finish) begin
                state_next = S_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // apb and register file
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else if (I_CE) begin
            pready_reg <= access;
            pslverr_reg <= access & bad;
            prdata_reg <= (access & ~bad & ~I_PWRITE) ? {24'h0, rd_byte} : 32'h0;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            libcfg_reg <= hps_pkg::RST_LIBCFG;
            rtamp_reg <= hps_pkg::RST_RTAMP;
            mode_reg <= hps_pkg::RST_MODE;
            go_reg <= 1'b0;
        end else if (I_CE) begin
            go_reg <= go_next;
            if (wr && pidx == hps_pkg::IDX_LIBCFG) begin
                libcfg_reg <= wdata;
            end
            if (wr && pidx == hps_pkg::IDX_RTAMP) begin
                rtamp_reg <= wdata;
            end
            if (wr && pidx == hps_pkg::IDX_MODE) begin
                mode_reg <= wdata[1:0];
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            for (int i = 0; i < hps_pkg::NUM_SLOTS; i++) begin
                slot_reg[i] <= (i == 0) ? hps_pkg::RST_SLOT1 : hps_pkg::RST_SLOTN;
            end
        end else if (I_CE && wr && is_slot) begin
            slot_reg[slot_sel] <= wdata;
        end
    end

    // ------------------------------------------------------------
    // sequencer and load drive
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            state_reg <= S_IDLE;
            idx_reg <= 3'h0;
            cnt_reg <= 32'h0;
            left_reg <= 7'h00;
        end else if (I_CE) begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            cnt_reg <= cnt_next;
            left_reg <= left_next;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            amp_reg <= 8'sh00;
            drive_en_reg <= 1'b0;
            start_reg <= 1'b0;
            tick_reg <= 1'b0;
            lib_reg <= 1'b0;
            id_reg <= 7'h00;
        end else if (I_CE) begin
            // signed value passes unscaled in real-time mode
            amp_reg <= (state_reg == S_RTP) ? rtamp_reg :
                (state_reg == S_PLAY) ? scaled : 8'sh00;
            drive_en_reg <= go_reg && (state_reg == S_RTP || state_reg == S_PLAY);
            start_reg <= start_next;
            tick_reg <= state_reg == S_PLAY && cnt_wrap;
            if (start_next) begin
                lib_reg <= libcfg_reg.lib_sel;
                id_reg <= cur.slot_identifier;
            end
        end
    end

    assign O_PRDATA = prdata_reg;
    assign O_PREADY = pready_reg;
    assign O_PSLVERR = pslverr_reg;
    assign O_DRIVE_AMP = amp_reg;
    assign O_DRIVE_EN = drive_en_reg;
    assign O_WAVE_ID = id_reg;
    assign O_WAVE_LIB = lib_reg;
    assign O_WAVE_START = start_reg;
    assign O_PLAY_TICK = tick_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    amp_reset_a: assert property ($rose(I_RESET_N) |-> rtamp_reg == 8'sh7f)
        else $error("amplitude reset value wrong");
    wave_start_a: assert property (I_CE && start_next |=> O_WAVE_START
        && O_WAVE_LIB == $past(libcfg_reg.lib_sel) && O_WAVE_ID == $past(cur.slot_identifier))
        else $error("waveform start fields wrong");
    lib_scale_a: assert property (I_CE && state_reg == S_PLAY |=>
        O_DRIVE_AMP == $past(scaled)) else $error("library drive not scaled");
    rt_drive_a: assert property (I_CE && state_reg == S_RTP |=>
        O_DRIVE_AMP == $past(rtamp_reg)) else $error("real-time drive wrong");
    // counted against the plain limits, so a wrong limit mux shows up
    tick_period_a: assert property (I_CE && state_reg == S_PLAY
        && cnt_reg == (libcfg_reg.interval_fast ? TICK_FAST_CYC : TICK_SLOW_CYC) - 1
        |=> O_PLAY_TICK) else $error("tick period wrong");
    delay_hold_a: assert property (I_CE && go_reg && state_reg == S_WAIT && left_reg != 7'h00
        && !go_clr |=> state_reg == S_WAIT) else $error("delay ended early");
    seq_start_a: assert property (I_CE && go_reg && state_reg == S_IDLE
        && mode_reg == hps_pkg::MODE_SEQUENCE |=> state_reg == S_FETCH && idx_reg == 3'h0)
        else $error("sequence did not start at first slot");
    slot_advance_a: assert property (I_CE && go_reg && slot_end && !last
        |=> idx_reg == $past(idx_reg) + 3'h1) else $error("slot not advanced");
    self_clear_a: assert property (I_CE && finish && !go_set |=> !go_reg)
        else $error("trigger bit not cleared");
    cancel_a: assert property (I_CE && !go_reg |=> state_reg == S_IDLE)
        else $error("playback not cancelled");
    hw_trig_a: assert property (I_CE && I_HW_TRIG |=> go_reg)
        else $error("hardware trigger lost");
    apb_wait_a: assert property (I_CE && access |=> O_PREADY)
        else $error("apb answer late");

    // outcomes held against the rules, not against the datapath terms
    zero_stop_a: assert property (I_CE && go_reg && zero_stop && !go_set |=>
        !go_reg && state_reg == S_IDLE) else $error("sequence ran past zero slot");
    last_stop_a: assert property (I_CE && go_reg && slot_end && last && !go_set |=>
        !go_reg && state_reg == S_IDLE) else $error("sequence ran past last slot");
    delay_quiet_a: assert property (I_CE && state_reg == S_WAIT |=> !O_DRIVE_EN
        && O_DRIVE_AMP == 8'sh00) else $error("load driven during delay");
    delay_no_wave_a: assert property (I_CE && state_reg == S_FETCH && cur.slot_delay_flag
        |=> !O_WAVE_START) else $error("delay slot started a waveform");
    go_hold_a: assert property (I_CE && go_reg && !go_clr |=> go_reg)
        else $error("trigger bit dropped while running");
    rt_enable_a: assert property (I_CE && go_reg && state_reg == S_RTP |=> O_DRIVE_EN)
        else $error("real-time drive not enabled");
    tick_idle_a: assert property (I_CE && state_reg != S_PLAY |=> !O_PLAY_TICK)
        else $error("tick outside playback");
    rt_gain_a: assert property (I_CE && state_reg == S_RTP
        && libcfg_reg.library_attenuation != 2'h0 |=> O_DRIVE_AMP == $past(rtamp_reg))
        else $error("attenuation applied in real-time mode");
endmodule : hps_regs

// file: tb/hps_lib_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// library player: done pulse a fixed time after each start
// ------------------------------------------------------------
module hps_lib_model #(
    parameter int LEN = 60
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    output logic o_done,
    output logic signed [7:0] o_sample
);
    int cnt;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt <= 0;
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt == 1);
            cnt <= i_start ? LEN : (cnt > 0 ? cnt - 1 : 0);
        end
    end
    // idle sample is the inverse, so a stale value never looks right
    assign o_sample = (cnt > 0) ? 8'sh40 : 8'shbf;
endmodule : hps_lib_model

// file: tb/hps_regs_tb.sv
`timescale 1ns/1ps
module hps_regs_tb;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, hw = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, err, done, en, wstart, tick, wlib;
    logic signed [7:0] samp, amp;
    logic [6:0] wid;
    logic [6:0] ids [0:15];
    int fail_count = 0, check_count = 0, cyc = 0, n_st = 0, last_tick = 0, gap = 0, g;
    int st_cyc [0:15];
    logic [7:0] att [0:3] = '{8'h40, 8'h30, 8'h20, 8'h10};
    initial forever #2.5 clk = ~clk;
    // short counts keep the run brief: tick 20/4, wait unit 40
    hps_regs #(.TICK_SLOW_CYC(20), .TICK_FAST_CYC(4), .WAIT_UNIT_CYC(40)) dut_u (
        .I_CLK(clk), .I_RESET_N(rst_n), .I_CE(1'b1), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_HW_TRIG(hw), .I_WAVE_DONE(done),
        .I_LIB_SAMPLE(samp), .O_DRIVE_AMP(amp), .O_DRIVE_EN(en), .O_WAVE_ID(wid),
        .O_WAVE_LIB(wlib), .O_WAVE_START(wstart), .O_PLAY_TICK(tick));
    hps_lib_model #(.LEN(60)) lib_u (.i_clk(clk), .i_rst_n(rst_n), .i_start(wstart),
        .o_done(done), .o_sample(samp));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wstart === 1'b1) begin
            ids[n_st % 16] <= wid;
            st_cyc[n_st % 16] <= cyc;
            n_st <= n_st + 1;
        end
        if (tick === 1'b1) begin
            gap <= cyc - last_tick;
            last_tick <= cyc;
        end
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] v);
        check_count++;
        if (v !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, v);
        end
    endtask : check
    task automatic timeout(input string nm);
        fail_count++;
        $display("Error %s expected answer seen timeout", nm);
        tally_and_finish();
    endtask : timeout
    task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) timeout("pready");
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [5:0] idx, input logic [7:0] e, input string nm);
        apb(1'b0, idx, 8'h00);
        check(nm, {24'h0, e}, rdv);
    endtask : rd
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles
    task automatic wait_start(input int n);
        int k;
        for (k = 0; k < 400 && n_st < n; k++) cycles(1);
        if (k == 400) timeout("wave_start");
    endtask : wait_start
    // polling the trigger bit: it must drop by itself at the end
    task automatic wait_idle;
        int k;
        for (k = 0; k < 400; k++) begin
            apb(1'b0, hps_pkg::IDX_GO, 8'h00);
            if (rdv[0] === 1'b0) break;
        end
        if (k == 400) timeout("trigger_clear");
    endtask : wait_idle
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rd(hps_pkg::IDX_LIBCFG, 8'h00, "libcfg_reset");
        rd(hps_pkg::IDX_RTAMP, 8'h7f, "amp_reset");
        rd(hps_pkg::IDX_SLOT1, 8'h01, "slot1_reset");
        apb(1'b0, 6'h3f, 8'h00);
        check("unmapped_err", 32'h1, {31'h0, err});
        check("unmapped_data", 32'h0, rdv);
        for (g = 0; g < 4; g++) begin
            wr(hps_pkg::IDX_LIBCFG, {g[0], 1'b0, g[1], 3'b000, g[1:0]});
            wr(hps_pkg::IDX_SLOT1, {1'b0, 7'(g + 5)});
            wr(hps_pkg::IDX_GO, 8'h01);
            wait_start(g + 1);
            check("wave_id", 32'(g + 5), {25'h0, wid});
            check("wave_lib", {31'h0, g[0]}, {31'h0, wlib});
            cycles(50);
            check("lib_amp", {24'h0, att[g]}, {24'h0, amp});
            check("drive_en", 32'h1, {31'h0, en});
            check("tick_gap", g[1] ? 32'd4 : 32'd20, gap);
            wait_idle();
        end
        wr(hps_pkg::IDX_LIBCFG, 8'h00);
        wr(hps_pkg::IDX_SLOT1, 8'h07);
        wr(hps_pkg::IDX_SLOT1 + 6'h01, 8'h82);
        wr(hps_pkg::IDX_SLOT1 + 6'h02, 8'h09);
        wr(hps_pkg::IDX_SLOT1 + 6'h03, 8'h00);
        wr(hps_pkg::IDX_GO, 8'h01);
        wait_start(5);
        cycles(70);
        check("wait_en", 32'h0, {31'h0, en});
        wait_start(6);
        check("seq_first", 32'h7, {25'h0, ids[4]});
        check("seq_next", 32'h9, {25'h0, ids[5]});
        check("delay_gap", 32'h1, {31'h0, (st_cyc[5] - st_cyc[4]) inside {[140:170]}});
        wait_idle();
        for (g = 0; g < 8; g++) wr(hps_pkg::IDX_SLOT1 + 6'(g), 8'(g + 1));
        wr(hps_pkg::IDX_GO, 8'h01);
        wait_idle();
        check("slot_count", 32'd8, 32'(n_st - 6));
        check("last_slot", 32'h8, {25'h0, ids[13]});
        wr(hps_pkg::IDX_MODE, 8'h01);
        wr(hps_pkg::IDX_LIBCFG, 8'h03);
        wr(hps_pkg::IDX_RTAMP, 8'h85);
        wr(hps_pkg::IDX_GO, 8'h01);
        cycles(6);
        check("rt_amp", 32'h85, {24'h0, amp});
        check("rt_sign", 32'h1, {31'h0, amp < 8'sh00});
        check("rt_en", 32'h1, {31'h0, en});
        wr(hps_pkg::IDX_RTAMP, 8'h22);
        cycles(3);
        check("rt_follow", 32'h22, {24'h0, amp});
        rd(hps_pkg::IDX_GO, 8'h01, "go_running");
        wr(hps_pkg::IDX_GO, 8'h00);
        cycles(3);
        check("rt_cancel", 32'h0, {31'h0, en});
        wr(hps_pkg::IDX_MODE, 8'h00);
        wr(hps_pkg::IDX_SLOT1, 8'h03);
        wr(hps_pkg::IDX_SLOT1 + 6'h01, 8'h00);
        @(posedge clk);
        hw <= 1'b1;
        @(posedge clk);
        hw <= 1'b0;
        rd(hps_pkg::IDX_GO, 8'h01, "hw_go");
        wait_start(15);
        check("hw_id", 32'h3, {25'h0, wid});
        wr(hps_pkg::IDX_GO, 8'h00);
        cycles(3);
        check("cancel_en", 32'h0, {31'h0, en});
        check("cancel_amp", 32'h0, {24'h0, amp});
        tally_and_finish();
    end
endmodule : hps_regs_tb
